//--- rtl/acmp_params.svh
// Offsets, field positions and reset values of the comparator control block
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH
// Register byte addresses on the APB side
`define ACMP_ADDR_W 8
`define ACMP_OFS_CTRL_A 8'h00
`define ACMP_OFS_CTRL_B 8'h04
`define ACMP_CH_STRIDE 8'h08
`define ACMP_OFS_MIRROR 8'h20
`define ACMP_OFS_FLAGS 8'h24
`define ACMP_MAX_CMP 4
// Control A fields
`define ACMP_A_ON 7
`define ACMP_A_OUT 6
`define ACMP_A_OE 5
`define ACMP_A_POL 4
`define ACMP_A_SP 2
`define ACMP_A_HYS 1
`define ACMP_A_SYNC 0
`define ACMP_A_WMASK 8'hB7
`define ACMP_A_RST 8'h04
// Control B fields
`define ACMP_B_INTP 7
`define ACMP_B_INTN 6
`define ACMP_B_PCH_HI 5
`define ACMP_B_PCH_LO 4
`define ACMP_B_NCH_HI 1
`define ACMP_B_NCH_LO 0
`define ACMP_B_WMASK 8'hF3
`define ACMP_B_RST 8'h00
`endif

//--- rtl/acmp_pkg.sv
// Types shared by the comparator control block
package acmp_pkg;
   // Register image, one byte per control register
   typedef logic [7:0] acmp_reg_t;
   // Sources for the noninverting input
   typedef enum logic [1:0] {
      ACMP_PSEL_PIN = 2'h0,
      ACMP_PSEL_DAC = 2'h1,
      ACMP_PSEL_REF = 2'h2,
      ACMP_PSEL_GND = 2'h3
   } acmp_psel_t;
endpackage

//--- rtl/acmp_chan.sv
// One comparator channel: input sync, polarity, latching and edge detection
`timescale 1ns/1ps
module acmp_chan
   import acmp_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic raw_in, // Raw analog comparator output, asynchronous
   input wire logic tclk_fall, // Falling edge of prescaled timer clock
   input wire logic instr_tick, // Instruction cycle strobe
   input wire logic on, // Comparator on
   input wire logic pol, // Output invert
   input wire logic sync_en, // Timer sync enable
   output logic result_q, // Latched internal result
   output logic pin_val, // Value routed to the pin
   output logic tsync_q, // Timer-synchronised result
   output logic rise, // Rising edge of latched result
   output logic fall // Falling edge of latched result
);
   logic raw_s1_q; // First sync stage, read only by the second
   logic raw_s2_q; // Synchronised raw result
   logic prev_q; // Result one cycle back
   logic pol_raw; // Polarity-adjusted result
   logic result_d;

   // Comparator already gives low for VIN+ below VIN-, high above
   assign pol_raw = raw_s2_q ^ pol;
   // Pin path always skips the instruction latch; timer sync picks the falling-edge capture instead
   assign pin_val = sync_en ? tsync_q : pol_raw;
   // Off forces low so downstream never sees a stale level
   assign result_d = !on ? 1'b0 : (instr_tick ? pol_raw : result_q);
   // Edges seen on the latched, polarity-adjusted result
   assign rise = result_q & ~prev_q;
   assign fall = ~result_q & prev_q;

   // Two-stage synchroniser on the analog output
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         raw_s1_q <= 1'b0;
         raw_s2_q <= 1'b0;
      end else if (ce) begin
         raw_s1_q <= raw_in;
         raw_s2_q <= raw_s1_q;
      end
   end

   // Result latch and edge history
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         result_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce) begin
         result_q <= result_d;
         prev_q <= result_q;
      end
   end

   // Capture on timer falling edge so rising-edge counting never races
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tsync_q <= 1'b0;
      end else if (ce && tclk_fall) begin
         tsync_q <= pol_raw;
      end
   end

   a_result_pol: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ce && on && instr_tick) |=> (result_q == ($past(raw_s2_q) ^ $past(pol))))
      else $error("latched result disagrees with polarity");
   a_tsync_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!tclk_fall || !ce) |=> $stable(tsync_q))
      else $error("timer sync value moved off the falling edge");
endmodule

//--- rtl/acmp_ctrl.sv
// Comparator control block: APB registers, pin routing and edge flags
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "acmp_params.svh"
module acmp_ctrl
   import acmp_pkg::*;
#(
   parameter int NUM_CMP = 2 // Number of comparators
)(
   input wire logic sys_clk, // 40 MHz system clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [`ACMP_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [NUM_CMP-1:0] cmp_raw, // Analog comparator outputs, async
   input wire logic tmr_clk_pre, // Prescaled timer clock, async
   input wire logic instr_tick, // Instruction cycle strobe
   input wire logic [NUM_CMP-1:0] pin_dir, // Pin direction, 1 is input
   input wire logic [NUM_CMP-1:0] port_latch, // Port data latch values
   output logic [NUM_CMP-1:0] cmp_on, // Analog enable per comparator
   output logic [NUM_CMP-1:0] cmp_normal_speed, // 1 normal speed, 0 low power
   output logic [NUM_CMP-1:0] cmp_hyst_en, // Hysteresis enable
   output logic [2*NUM_CMP-1:0] pos_sel, // Noninverting source select
   output logic [2*NUM_CMP-1:0] neg_sel, // Inverting pin select
   output logic [NUM_CMP-1:0] cmp_result, // Latched internal result
   output logic [NUM_CMP-1:0] sync_result, // Timer-synchronised result
   output logic [NUM_CMP-1:0] pin_data, // Value on the pin when overridden
   output logic [NUM_CMP-1:0] pin_oe, // Pin output enable
   output logic [NUM_CMP-1:0] port_override, // Pin takes comparator not latch
   output logic [NUM_CMP-1:0] irq_flag // Sticky edge flags
);
   // Elaboration check on channel count
   if (NUM_CMP < 1 || NUM_CMP > `ACMP_MAX_CMP) begin : g_bad_count
      $error("NUM_CMP out of range");
   end

   acmp_reg_t ctrl_a_q [NUM_CMP]; // First control register per comparator
   acmp_reg_t ctrl_b_q [NUM_CMP]; // Second control register per comparator
   logic [NUM_CMP-1:0] flag_q; // Sticky edge flags
   logic [NUM_CMP-1:0] flag_d;
   logic [31:0] prdata_q; // Read data latched in setup
   logic [31:0] prdata_d;
   logic pslverr_q; // Error latched in setup
   logic tclk_s1_q; // Timer clock sync stage one
   logic tclk_s2_q; // Timer clock sync stage two
   logic tclk_s3_q; // Timer clock history for edge
   logic tclk_fall; // Timer clock falling edge
   logic setup_ph; // APB setup cycle
   logic wr_en; // APB write commits
   logic [NUM_CMP-1:0] sel_a; // Control A hit
   logic [NUM_CMP-1:0] sel_b; // Control B hit
   wire sel_mirror = (paddr == `ACMP_OFS_MIRROR);
   wire sel_flags = (paddr == `ACMP_OFS_FLAGS);
   wire any_hit = (|sel_a) | (|sel_b) | sel_mirror | sel_flags;
   logic [NUM_CMP-1:0] rise; // Channel rising edges
   logic [NUM_CMP-1:0] fall; // Channel falling edges
   logic [NUM_CMP-1:0] pin_val; // Channel pin values
   logic [NUM_CMP-1:0] edge_hit; // Qualified edges
   logic [NUM_CMP-1:0] flag_clr; // Software clear, write one to clear

   // Single-cycle slave: ready whenever the block is clocked
   assign setup_ph = psel & ~penable;
   assign pready = ce;
   assign wr_en = psel & penable & pwrite & ce & ~pslverr_q;
   assign prdata = prdata_q;
   assign pslverr = psel & penable & pslverr_q;
   assign flag_clr = (wr_en && sel_flags) ? pwdata[NUM_CMP-1:0] : '0;
   // Set beats clear in the same cycle
   assign flag_d = (flag_q & ~flag_clr) | edge_hit;
   assign irq_flag = flag_q;

   // Timer clock synchroniser and falling-edge detect
   assign tclk_fall = tclk_s3_q & ~tclk_s2_q;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tclk_s1_q <= 1'b0;
         tclk_s2_q <= 1'b0;
         tclk_s3_q <= 1'b0;
      end else if (ce) begin
         tclk_s1_q <= tmr_clk_pre;
         tclk_s2_q <= tclk_s1_q;
         tclk_s3_q <= tclk_s2_q;
      end
   end

   // Per-comparator decode, routing and channel logic
   for (genvar i = 0; i < NUM_CMP; i++) begin : g_ch
      localparam logic [`ACMP_ADDR_W-1:0] OFS = `ACMP_ADDR_W'(i * `ACMP_CH_STRIDE);
      wire on_b = ctrl_a_q[i][`ACMP_A_ON];
      wire oe_b = ctrl_a_q[i][`ACMP_A_OE];

      // Two registers for each comparator
      assign sel_a[i] = (paddr == (`ACMP_OFS_CTRL_A + OFS));
      assign sel_b[i] = (paddr == (`ACMP_OFS_CTRL_B + OFS));
      assign cmp_on[i] = on_b;
      assign cmp_normal_speed[i] = ctrl_a_q[i][`ACMP_A_SP];
      assign cmp_hyst_en[i] = ctrl_a_q[i][`ACMP_A_HYS];
      assign pos_sel[2*i +: 2] = ctrl_b_q[i][`ACMP_B_PCH_HI:`ACMP_B_PCH_LO];
      assign neg_sel[2*i +: 2] = ctrl_b_q[i][`ACMP_B_NCH_HI:`ACMP_B_NCH_LO];
      // Override follows enable alone; the driver also needs on and output dir
      assign port_override[i] = oe_b;
      assign pin_oe[i] = oe_b & ~pin_dir[i] & on_b;
      assign pin_data[i] = oe_b ? pin_val[i] : port_latch[i];
      assign edge_hit[i] = (rise[i] & ctrl_b_q[i][`ACMP_B_INTP]) |
                           (fall[i] & ctrl_b_q[i][`ACMP_B_INTN]);

      acmp_chan u_chan (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .ce(ce),
         .raw_in(cmp_raw[i]),
         .tclk_fall(tclk_fall),
         .instr_tick(instr_tick),
         .on(on_b),
         .pol(ctrl_a_q[i][`ACMP_A_POL]),
         .sync_en(ctrl_a_q[i][`ACMP_A_SYNC]),
         .result_q(cmp_result[i]),
         .pin_val(pin_val[i]),
         .tsync_q(sync_result[i]),
         .rise(rise[i]),
         .fall(fall[i])
      );

      // Control registers; the result bit is never stored
      always_ff @(posedge sys_clk) begin
         if (!rstn) begin
            ctrl_a_q[i] <= `ACMP_A_RST;
            ctrl_b_q[i] <= `ACMP_B_RST;
         end else if (wr_en && sel_a[i]) begin
            ctrl_a_q[i] <= pwdata[7:0] & `ACMP_A_WMASK;
         end else if (wr_en && sel_b[i]) begin
            ctrl_b_q[i] <= pwdata[7:0] & `ACMP_B_WMASK;
         end
      end

      a_pin_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
         pin_oe[i] |-> (cmp_on[i] && !pin_dir[i] && port_override[i]))
         else $error("pin driven without all enables");
      a_override_on: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && !(wr_en && sel_a[i])) |=> $stable(port_override[i]))
         else $error("override changed without a write");
      a_off_low: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && !cmp_on[i]) |=> !cmp_result[i])
         else $error("result not low while off");
      a_latch_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && cmp_on[i] && !instr_tick) |=> $stable(cmp_result[i]))
         else $error("result moved between instruction ticks");
      a_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && rise[i] && ctrl_b_q[i][`ACMP_B_INTP]) |=> irq_flag[i])
         else $error("enabled rising edge missed");
      a_flag_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && flag_clr[i] && edge_hit[i]) |=> irq_flag[i] [*1])
         else $error("edge lost during clear");
      a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
         (irq_flag[i] && !flag_clr[i]) |=> irq_flag[i])
         else $error("flag dropped without a clear");
      a_edge_src: assert property (@(posedge sys_clk) disable iff (!rstn)
         (ce && rise[i] && $past(ce)) |-> (cmp_result[i] && !$past(cmp_result[i])))
         else $error("edge not from latched result");
      c_flag_rise: cover property (@(posedge sys_clk) disable iff (!rstn)
         ce && rise[i] ##1 irq_flag[i]);
      c_pin_drive: cover property (@(posedge sys_clk) disable iff (!rstn)
         pin_oe[i] && pin_data[i]);
      c_sync_cap: cover property (@(posedge sys_clk) disable iff (!rstn)
         ctrl_a_q[i][`ACMP_A_SYNC] && tclk_fall && ce);
   end

   // Read mux, priority chain across the register map
   always_comb begin
      prdata_d = 32'h0000_0000;
      for (int k = 0; k < NUM_CMP; k++) begin
         if (sel_a[k]) begin
            prdata_d[7:0] = ctrl_a_q[k];
            prdata_d[`ACMP_A_OUT] = cmp_result[k];
         end else if (sel_b[k]) begin
            prdata_d[7:0] = ctrl_b_q[k];
         end
      end
      if (sel_mirror) begin
         prdata_d[NUM_CMP-1:0] = cmp_result;
      end else if (sel_flags) begin
         prdata_d[NUM_CMP-1:0] = flag_q;
      end
   end

   // Read data and error captured in setup so the data output is a flop
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce && setup_ph) begin
         prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
         pslverr_q <= ~any_hit;
      end
   end

   // Sticky edge flags
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         flag_q <= '0;
      end else if (ce) begin
         flag_q <= flag_d;
      end
   end

   a_speed_reset: assert property (@(posedge sys_clk)
      !rstn |=> (cmp_normal_speed == {NUM_CMP{1'b1}}))
      else $error("speed select not normal after reset");
   a_mirror_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ce && setup_ph && !pwrite && sel_mirror) |=>
         (prdata[NUM_CMP-1:0] == $past(cmp_result)))
      else $error("mirror read wrong");
   a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ce && setup_ph && !any_hit) ##1 (psel && penable) |-> pslverr)
      else $error("unmapped access not refused");
   c_write_a: cover property (@(posedge sys_clk) disable iff (!rstn)
      wr_en && |sel_a);
endmodule

//--- test/acmp_ctrl_tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "acmp_params.svh"
module acmp_ctrl_tb_top
   import acmp_pkg::*;
;
   logic sys_clk = 1'b0; // Bench clock, 25 ns period
   logic rstn = 1'b0; // Reset, active low
   logic ce = 1'b1; // Clock enable
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
   logic [7:0] paddr = 8'h00; // APB address
   logic [31:0] pwdata = 32'h0, prdata; // APB data
   logic pready, pslverr; // APB answer
   logic [1:0] cmp_raw = 2'h0, pin_dir = 2'h0, port_latch = 2'h2; // Analog and port inputs
   logic tmr_clk_pre = 1'b0, instr_tick = 1'b0; // Timer clock and cycle strobe
   logic [1:0] cmp_on, cmp_normal_speed, cmp_hyst_en, cmp_result; // Channel outputs
   logic [1:0] sync_result, pin_data, pin_oe, port_override, irq_flag; // Pin and flag outputs
   logic [3:0] pos_sel, neg_sel; // Input selects
   logic [1:0] div_q = 2'h0; // Divider for strobe and timer clock
   int fail_count = 0; // Mismatches
   int total_checks = 0; // Comparisons
   acmp_ctrl #(.NUM_CMP(2)) acmp_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_raw(cmp_raw), .tmr_clk_pre(tmr_clk_pre), .instr_tick(instr_tick),
      .pin_dir(pin_dir), .port_latch(port_latch), .cmp_on(cmp_on), .cmp_normal_speed(cmp_normal_speed),
      .cmp_hyst_en(cmp_hyst_en), .pos_sel(pos_sel), .neg_sel(neg_sel), .cmp_result(cmp_result),
      .sync_result(sync_result), .pin_data(pin_data), .pin_oe(pin_oe), .port_override(port_override),
      .irq_flag(irq_flag));
   // Clock
   always #12.5 sys_clk = ~sys_clk;
   // Strobe every fourth cycle, timer clock at an eighth of the rate
   always @(posedge sys_clk) begin
      div_q <= div_q + 2'h1;
      instr_tick <= (div_q == 2'h0);
      if (div_q == 2'h0) begin
         tmr_clk_pre <= ~tmr_clk_pre;
      end
   end
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Next pseudo-random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // One APB transfer; a new setup never shares an edge with a release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask
   // Let synchronisers, strobe and timer edges pass
   task automatic settle();
      repeat (24) @(posedge sys_clk);
   endtask
   // Clear every flag, write one to clear
   task automatic clr();
      logic [31:0] rd;
      logic er;
      apb(1'b1, `ACMP_OFS_FLAGS, 32'hFF, rd, er);
   endtask
   // Main sequence
   initial begin
      logic [31:0] r, rd;
      logic [7:0] a, b;
      logic er, res;
      int ch, n;
      r = 32'h5;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(pin_oe, 2'h0);
      chk(pin_data, 2'h2);
      chk(cmp_result, 2'h0);
      for (int c = 0; c < 2; c++) begin
         apb(1'b0, 8'(`ACMP_OFS_CTRL_A + `ACMP_CH_STRIDE * c), 32'h0, rd, er);
         chk(rd, 32'h04);
         apb(1'b0, 8'(`ACMP_OFS_CTRL_B + `ACMP_CH_STRIDE * c), 32'h0, rd, er);
         chk(rd, 32'h00);
      end
      // Random settings on random channels
      for (int i = 0; i < 24; i++) begin
         r = xs(r);
         ch = int'(r[8]);
         a = r[7:0];
         b = {r[15:14], 2'(i), 2'h0, r[17:16]};
         cmp_raw <= r[19:18];
         pin_dir <= r[21:20];
         port_latch <= r[23:22];
         apb(1'b1, 8'(`ACMP_OFS_CTRL_A + `ACMP_CH_STRIDE * ch), {24'h0, a}, rd, er);
         apb(1'b1, 8'(`ACMP_OFS_CTRL_B + `ACMP_CH_STRIDE * ch), {24'h0, b}, rd, er);
         settle();
         res = a[7] & (r[18 + ch] ^ a[4]);
         apb(1'b0, 8'(`ACMP_OFS_CTRL_A + `ACMP_CH_STRIDE * ch), 32'h0, rd, er);
         chk(rd, {24'h0, (a & `ACMP_A_WMASK) | {1'b0, res, 6'h0}});
         apb(1'b0, 8'(`ACMP_OFS_CTRL_B + `ACMP_CH_STRIDE * ch), 32'h0, rd, er);
         chk(rd, {24'h0, b & `ACMP_B_WMASK});
         apb(1'b0, `ACMP_OFS_MIRROR, 32'h0, rd, er);
         chk(rd[ch], res);
         chk(cmp_result[ch], res);
         chk(cmp_on[ch], a[7]);
         chk(cmp_normal_speed[ch], a[2]);
         chk(cmp_hyst_en[ch], a[1]);
         chk(port_override[ch], a[5]);
         chk(pin_oe[ch], a[5] & ~r[20 + ch] & a[7]);
         chk(pos_sel[2 * ch +: 2], b[5:4]);
         chk(neg_sel[2 * ch +: 2], b[1:0]);
         if (!a[5]) begin
            chk(pin_data[ch], r[22 + ch]);
         end else if (a[7] && !a[0]) begin
            chk(pin_data[ch], res);
         end
         if (a[7] && a[0]) begin
            chk(sync_result[ch], res);
         end
      end
      // Unmapped place is refused
      apb(1'b0, 8'h30, 32'h0, rd, er);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      // Frozen clock enable holds the bus waiting
      @(posedge sys_clk);
      ce <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(pready, 1'b0);
      @(posedge sys_clk);
      ce <= 1'b1;
      // Each edge enable alone on channel zero
      apb(1'b1, `ACMP_OFS_CTRL_A, 32'h84, rd, er);
      for (int e = 1; e < 3; e++) begin
         apb(1'b1, `ACMP_OFS_CTRL_B, {24'h0, 2'(e), 6'h0}, rd, er);
         cmp_raw <= 2'h0;
         settle();
         clr();
         cmp_raw <= 2'h1;
         settle();
         apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
         chk(rd[0], e == 2);
         clr();
         apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
         chk(rd[0], 1'b0);
         cmp_raw <= 2'h0;
         settle();
         apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
         chk(rd[0], e == 1);
         clr();
      end
      // Clear landing in the edge's own cycle; rise enable still set
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (instr_tick !== 1'b1 && n < 8);
      if (instr_tick !== 1'b1) begin
         fail_count++;
         finish_test();
      end
      // Tick seen now, next one in four edges; raw is through the sync in two
      cmp_raw <= 2'h1;
      repeat (2) @(posedge sys_clk);
      // Access phase of this clear meets the flag-setting edge
      clr();
      apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
      chk(rd[0], 1'b1);
      chk(irq_flag[0], 1'b1);
      clr();
      cmp_raw <= 2'h0;
      settle();
      // Invert and switch-off themselves make edges
      apb(1'b1, `ACMP_OFS_CTRL_B, 32'hC0, rd, er);
      apb(1'b1, `ACMP_OFS_CTRL_A, 32'h94, rd, er);
      settle();
      apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
      chk(rd[0], 1'b1);
      clr();
      apb(1'b1, `ACMP_OFS_CTRL_A, 32'h14, rd, er);
      settle();
      chk(cmp_result[0], 1'b0);
      apb(1'b0, `ACMP_OFS_FLAGS, 32'h0, rd, er);
      chk(rd[0], 1'b1);
      finish_test();
   end
endmodule
